// *** verilog/rps_map.svh ***
// Widths, reset values and timing counts of the reset pin sequencer
`ifndef RPS_MAP_SVH
`define RPS_MAP_SVH

// Clock period of sys_clk_i in ns (50 MHz)
`define RPS_CLK_PERIOD_NS    20
// Longest time from reset pin release to reset pull-down off
`define RPS_PD_RELEASE_NS    1500000
// Longest time rounds down
`define RPS_PD_RELEASE_CYC   (`RPS_PD_RELEASE_NS / `RPS_CLK_PERIOD_NS)
// Delay from reset release to strap sampling ("a few ms")
`define RPS_STRAP_DELAY_NS   2000000
// Least time rounds up
`define RPS_STRAP_DELAY_CYC  ((`RPS_STRAP_DELAY_NS + `RPS_CLK_PERIOD_NS - 1) / `RPS_CLK_PERIOD_NS)
// Cycles of pin-to-pad latency: two sync stages, state and output
`define RPS_PIN_LAT          4
// Width of the release counter
`define RPS_CNT_W            17
// Number of RF switch control pins
`define RPS_RF_W             4
// RF switch pulls while in reset: first up, the other three down
`define RPS_RF_PU_RESET      4'h1
`define RPS_RF_PD_RESET      4'he
`define RPS_RF_OE_RUN        4'hf
// Host interface select strap encoding
`define RPS_HOST_SDIO        1'b0
`define RPS_HOST_SPI         1'b1
// Strap values before sampling: SDIO host, open-source clock request
`define RPS_STRAP_DEFAULT    2'h0

`endif

// *** verilog/rps_pkg.sv ***
// Types of the reset pin sequencer
`include "rps_map.svh"
package rps_pkg;

   typedef enum logic [1:0] {ph_reset, ph_wait, ph_run} rps_phase_t;

   // Software controls of the pad pulls
   typedef struct packed {
      logic rst_pd_en;     // Re-enable weak pull-down on reset input
      logic req_pd_dis;    // Disable pull-downs on regulator requests
      logic host_pu_dis;   // Disable pull-ups on host interface pins
   } rps_sw_ctl_t;

   // Latched strap levels
   typedef struct packed {
      logic spi_mode;          // 0 SDIO, 1 generic serial host
      logic clkreq_push_pull;  // 0 open-source, 1 push-pull
   } rps_straps_t;

   // Pad controls
   typedef struct packed {
      logic rst_pd_en;       // Pull-down on the reset input
      logic req_pd_en;       // Pull-downs on the regulator request inputs
      logic host_hiz;        // Host interface pins high impedance
      logic host_pu_en;      // Weak pull-ups on host interface pins
      logic strap_sampling;  // Strap pins held as inputs for sampling
   } rps_pad_ctl_t;

   typedef struct packed {
      logic out;
      logic oe;
      logic pd_en;
   } rps_clkreq_pin_t;

   typedef struct packed {
      logic [`RPS_RF_W-1:0] out;
      logic [`RPS_RF_W-1:0] oe;
      logic [`RPS_RF_W-1:0] pu_en;
      logic [`RPS_RF_W-1:0] pd_en;
   } rps_rf_pins_t;

   typedef struct packed {
      rps_phase_t            phase;
      logic [`RPS_CNT_W-1:0] cnt;
      logic                  pd_released;
      logic                  straps_valid;
      rps_straps_t           straps;
      rps_pad_ctl_t          pad;
      rps_clkreq_pin_t       clkreq;
      rps_rf_pins_t          rf;
      logic                  reg_req;
      logic                  pwm_req;
   } rps_state_t;

endpackage : rps_pkg

// *** verilog/rps_sync2.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module rps_sync2 #(
   parameter int W = 1
) (
   input  wire logic         sys_clk_i,  // System clock
   input  wire logic         srst_i,     // Synchronous reset
   input  wire logic         clk_en_i,   // Clock enable
   input  wire logic [W-1:0] async_i,    // Pin levels
   output logic      [W-1:0] sync_o      // Synchronised levels
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } rps_sync_state_t;

   rps_sync_state_t st;
   rps_sync_state_t next_st;

   // First stage feeds only the second
   always_comb begin
      next_st.s1 = async_i;
      next_st.s2 = st.s1;
   end

   // Register both stages
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         st <= '0;
      end else if (clk_en_i) begin
         st <= next_st;
      end
   end

   assign sync_o = st.s2;

endmodule : rps_sync2

// *** verilog/rps_seq.sv ***
// Reset pin state, pull control, clock request and strap sampling
`timescale 1ns/1ps
`include "rps_map.svh"
module rps_seq #(
   parameter int PD_RELEASE_CYC  = `RPS_PD_RELEASE_CYC,  // Reset pull-down release
   parameter int STRAP_DELAY_CYC = `RPS_STRAP_DELAY_CYC  // Strap sample delay
) (
   input  wire logic                    sys_clk_i,                 // 50 MHz clock
   input  wire logic                    srst_i,                    // Internal power-on reset
   input  wire logic                    clk_en_i,                  // Freezes state when low
   input  wire logic                    wlan_reset_in_n_i,         // Reset pin, active low
   input  wire logic                    ext_regulator_request_i,   // Regulator request pin
   input  wire logic                    ext_pulse_mode_request_i,  // Pulse mode request pin
   input  wire logic [1:0]              strap_pins_i,              // {host sel, clkreq mode}
   input  wire logic                    clock_wanted_i,            // Core wants a clock
   input  wire logic                    sleep_i,                   // Device in sleep mode
   input  wire logic [`RPS_RF_W-1:0]    rf_switch_value_i,         // RF switch levels
   input  rps_pkg::rps_sw_ctl_t         sw_ctl_i,                  // Software pull controls
   output rps_pkg::rps_pad_ctl_t        pad_ctl_o,                 // Pad pull and float
   output rps_pkg::rps_clkreq_pin_t     clock_request_out_o,       // Clock request pin
   output rps_pkg::rps_rf_pins_t        rf_switch_control_o,       // RF switch pins
   output rps_pkg::rps_straps_t         straps_o,                  // Latched straps
   output logic                         straps_valid_o,            // Straps sampled
   output logic                         device_in_reset_o,         // Reset phase active
   output logic                         ext_regulator_request_o,   // Synced request
   output logic                         ext_pulse_mode_request_o   // Synced request
);

   localparam logic [`RPS_CNT_W-1:0] PD_AT    = `RPS_CNT_W'(PD_RELEASE_CYC - `RPS_PIN_LAT);
   localparam logic [`RPS_CNT_W-1:0] STRAP_AT = `RPS_CNT_W'(STRAP_DELAY_CYC - 1);

   localparam rps_pkg::rps_state_t ST_RESET = '{
      phase:        rps_pkg::ph_reset,
      cnt:          '0,
      pd_released:  1'b0,
      straps_valid: 1'b0,
      straps:       `RPS_STRAP_DEFAULT,
      pad:          '{rst_pd_en: 1'b1, req_pd_en: 1'b1, host_hiz: 1'b1,
                      host_pu_en: 1'b0, strap_sampling: 1'b1},
      clkreq:       '{out: 1'b0, oe: 1'b0, pd_en: 1'b1},
      rf:           '{out: '0, oe: '0, pu_en: `RPS_RF_PU_RESET, pd_en: `RPS_RF_PD_RESET},
      reg_req:      1'b0,
      pwm_req:      1'b0
   };

   rps_pkg::rps_state_t  st;
   rps_pkg::rps_state_t  next_st;
   logic                 rst_n_s;
   logic                 reg_req_s;
   logic                 pwm_req_s;
   rps_pkg::rps_straps_t strap_s;
   logic                 in_rst;
   logic                 want;

   // All pin inputs pass two flip-flops
   rps_sync2 #(
      .W(5)
   ) u_sync (
      .sys_clk_i (sys_clk_i),
      .srst_i    (srst_i),
      .clk_en_i  (clk_en_i),
      .async_i   ({wlan_reset_in_n_i, ext_regulator_request_i,
                   ext_pulse_mode_request_i, strap_pins_i}),
      .sync_o    ({rst_n_s, reg_req_s, pwm_req_s, strap_s})
   );

   // Phase sequencing, strap latch and pad control
   always_comb begin
      next_st = st;
      case (st.phase)
         rps_pkg::ph_reset: begin
            if (rst_n_s) begin
               next_st.phase = rps_pkg::ph_wait;
            end
         end
         rps_pkg::ph_wait: begin
            if (!rst_n_s) begin
               next_st.phase = rps_pkg::ph_reset;
            end else begin
               next_st.cnt = st.cnt + `RPS_CNT_W'(1);
               if (st.cnt >= PD_AT) begin
                  next_st.pd_released = 1'b1;
               end
               if (st.cnt == STRAP_AT) begin
                  next_st.straps       = strap_s;
                  next_st.straps_valid = 1'b1;
                  next_st.phase        = rps_pkg::ph_run;
               end
            end
         end
         rps_pkg::ph_run: begin
            if (!rst_n_s) begin
               next_st.phase = rps_pkg::ph_reset;
            end
         end
         default: begin
            next_st.phase = rps_pkg::ph_reset;
         end
      endcase
      in_rst = (next_st.phase == rps_pkg::ph_reset);
      // Entering reset clears count and straps at once, so no pad sees stale values
      if (in_rst) begin
         next_st.cnt          = '0;
         next_st.pd_released  = 1'b0;
         next_st.straps_valid = 1'b0;
         next_st.straps       = `RPS_STRAP_DEFAULT;
      end
      // Reset pin pull-down: on until released, then software choice
      next_st.pad.rst_pd_en = next_st.pd_released ? sw_ctl_i.rst_pd_en : 1'b1;
      next_st.pad.req_pd_en = in_rst | ~sw_ctl_i.req_pd_dis;
      next_st.pad.host_hiz   = in_rst;
      next_st.pad.host_pu_en = ~in_rst & ~sw_ctl_i.host_pu_dis;
      next_st.pad.strap_sampling = ~next_st.straps_valid;
      // Clock request pin
      want = clock_wanted_i & ~sleep_i & ~in_rst;
      if (in_rst) begin
         next_st.clkreq = '{out: 1'b0, oe: 1'b0, pd_en: 1'b1};
      end else if (next_st.straps_valid && next_st.straps.clkreq_push_pull) begin
         next_st.clkreq = '{out: want, oe: 1'b1, pd_en: 1'b0};
      end else begin
         next_st.clkreq = '{out: 1'b1, oe: want, pd_en: ~want};
      end
      // RF switch pins
      if (in_rst) begin
         next_st.rf = '{out: '0, oe: '0, pu_en: `RPS_RF_PU_RESET,
                        pd_en: `RPS_RF_PD_RESET};
      end else begin
         next_st.rf = '{out: rf_switch_value_i, oe: `RPS_RF_OE_RUN,
                        pu_en: '0, pd_en: '0};
      end
      next_st.reg_req = reg_req_s;
      next_st.pwm_req = pwm_req_s;
   end

   // State register, frozen while the clock enable is low
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         st <= ST_RESET;
      end else if (clk_en_i) begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register
   assign pad_ctl_o                = st.pad;
   assign clock_request_out_o      = st.clkreq;
   assign rf_switch_control_o      = st.rf;
   assign straps_o                 = st.straps;
   assign straps_valid_o           = st.straps_valid;
   // Host float flop is set exactly while the phase is reset
   assign device_in_reset_o        = st.pad.host_hiz;
   assign ext_regulator_request_o  = st.reg_req;
   assign ext_pulse_mode_request_o = st.pwm_req;

   // Checks on the pad sequencing
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);

   a_rst_pd_release: assert property (
      (st.phase == rps_pkg::ph_wait && st.cnt > PD_AT) || st.phase == rps_pkg::ph_run
      |-> st.pd_released)
      else $error("reset pull-down not released in time");

   a_rst_pd_soft: assert property (
      clk_en_i && st.pd_released && rst_n_s
      |=> st.pad.rst_pd_en == $past(sw_ctl_i.rst_pd_en))
      else $error("reset pull-down ignores software");

   a_req_pd_keep: assert property (
      clk_en_i && !sw_ctl_i.req_pd_dis |=> st.pad.req_pd_en)
      else $error("regulator request pull-down dropped");

   a_host_pins: assert property (
      st.pad.host_hiz |-> !st.pad.host_pu_en)
      else $error("host pull-up on while floating");

   a_host_pu_run: assert property (
      clk_en_i && rst_n_s && st.phase == rps_pkg::ph_run && !sw_ctl_i.host_pu_dis
      |=> st.pad.host_pu_en && !st.pad.host_hiz)
      else $error("host pull-up missing after reset");

   a_clkreq_open: assert property (
      st.phase == rps_pkg::ph_run && !st.straps.clkreq_push_pull
      |-> st.clkreq.out && (st.clkreq.oe != st.clkreq.pd_en))
      else $error("open-source clock request wrong");

   a_clkreq_pp: assert property (
      st.phase == rps_pkg::ph_run && st.straps.clkreq_push_pull
      |-> st.clkreq.oe && !st.clkreq.pd_en)
      else $error("push-pull clock request not driven");

   a_clkreq_sleep: assert property (
      clk_en_i && sleep_i |=> !(st.clkreq.oe && st.clkreq.out))
      else $error("clock requested during sleep");

   a_strap_latch: assert property (
      clk_en_i && rst_n_s && st.phase == rps_pkg::ph_wait && st.cnt == STRAP_AT
      |=> st.straps_valid && st.straps == $past(strap_s))
      else $error("straps not latched at sample point");

   a_strap_release: assert property (
      st.straps_valid |-> !st.pad.strap_sampling)
      else $error("strap pins not returned to function");

   a_strap_default: assert property (
      !st.straps_valid |-> st.straps.spi_mode == `RPS_HOST_SDIO)
      else $error("host select not defaulting to SDIO");

   a_rf_reset: assert property (
      st.phase == rps_pkg::ph_reset |-> st.rf.oe == '0
      && st.rf.pu_en == `RPS_RF_PU_RESET && st.rf.pd_en == `RPS_RF_PD_RESET)
      else $error("RF switch pins wrong in reset");

   a_rf_run: assert property (
      st.phase == rps_pkg::ph_run |-> st.rf.oe == `RPS_RF_OE_RUN && st.rf.pu_en == '0)
      else $error("RF switch pins not driven after reset");

   c_run_reached: cover property (st.phase == rps_pkg::ph_run);
   c_soft_pd: cover property (st.pd_released && st.pad.rst_pd_en);
   c_push_pull: cover property (st.phase == rps_pkg::ph_run && st.straps.clkreq_push_pull);
   c_spi_host: cover property (st.straps_valid && st.straps.spi_mode == `RPS_HOST_SPI);

endmodule : rps_seq

// *** tb/rps_board_model.sv ***
// Board side of the block: reset source, strap resistors and reference clock source
`timescale 1ns/1ps
`include "rps_map.svh"
module rps_board_model (
   input  wire logic                 reset_hold_i,       // Board holds reset pin low
   input  wire logic [1:0]           strap_ovr_en_i,     // Strap resistor fitted
   input  wire logic [1:0]           strap_ovr_val_i,    // 1 pull-up, 0 pull-down
   input  rps_pkg::rps_clkreq_pin_t  clkreq_i,           // Clock request pad controls
   output logic                      wlan_reset_in_n_o,  // Reset pin level
   output logic [1:0]                strap_o,            // Strap pin levels
   output logic                      clock_running_o     // Reference clock answers
);
   logic clkreq_level;  // Resolved level of the clock request wire

   // Reset source drives the pin low while holding reset
   assign wlan_reset_in_n_o = ~reset_hold_i;
   // Fitted resistor wins, else the internal pull sets the default level
   assign strap_o = (strap_ovr_en_i & strap_ovr_val_i) |
                    (~strap_ovr_en_i & `RPS_STRAP_DEFAULT);
   // Undriven wire with pull-down reads low, with no pull it floats
   assign clkreq_level = clkreq_i.oe ? clkreq_i.out : (clkreq_i.pd_en ? 1'b0 : 1'bz);
   // Clock source runs only on a solid high request
   assign clock_running_o = (clkreq_level === 1'b1);
endmodule : rps_board_model

// *** tb/testbench.sv ***
// Self-checking testbench of the reset pin sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
   localparam int PD = 20;
   localparam int SD = 40;
   logic                            sys_clk_i = 1'b0;
   logic                            srst_i = 1'b1;
   logic                            hold = 1'b1;
   logic                            clk_en = 1'b1;
   logic [1:0]                      ovr_en = 2'h0;
   logic [1:0]                      ovr_val = 2'h0;
   logic                            rst_n, run_clk, reg_req, pwm_req, want, sleep, valid, in_rst;
   logic [1:0]                      straps_pin;
   logic [3:0]                      rf_val = 4'ha;
   rps_pkg::rps_sw_ctl_t            sw = '0;
   rps_pkg::rps_pad_ctl_t           pad;
   rps_pkg::rps_clkreq_pin_t        ck;
   rps_pkg::rps_rf_pins_t           rf;
   rps_pkg::rps_straps_t            st;
   logic                            reg_o, pwm_o;
   int                              err_count = 0;
   int                              checks_done = 0;

   initial begin
      forever #10 sys_clk_i = ~sys_clk_i;
   end

   rps_board_model board (.reset_hold_i(hold), .strap_ovr_en_i(ovr_en),
      .strap_ovr_val_i(ovr_val), .clkreq_i(ck), .wlan_reset_in_n_o(rst_n),
      .strap_o(straps_pin), .clock_running_o(run_clk));

   rps_seq #(.PD_RELEASE_CYC(PD), .STRAP_DELAY_CYC(SD)) dut (.sys_clk_i(sys_clk_i),
      .srst_i(srst_i), .clk_en_i(clk_en), .wlan_reset_in_n_i(rst_n),
      .ext_regulator_request_i(reg_req), .ext_pulse_mode_request_i(pwm_req),
      .strap_pins_i(straps_pin), .clock_wanted_i(want), .sleep_i(sleep),
      .rf_switch_value_i(rf_val), .sw_ctl_i(sw), .pad_ctl_o(pad), .clock_request_out_o(ck),
      .rf_switch_control_o(rf), .straps_o(st), .straps_valid_o(valid),
      .device_in_reset_o(in_rst), .ext_regulator_request_o(reg_o),
      .ext_pulse_mode_request_o(pwm_o));

   // Prints the counts and the verdict, then stops
   task automatic close_out;
      $display("Checks %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : close_out

   // Pads while the device sits in reset
   task automatic t_reset_state;
      `CHK(pad, 5'h1d)
      `CHK(ck, 3'h1)
      `CHK({rf.oe, rf.pu_en, rf.pd_en}, 12'h01e)
      `CHK({st, valid, in_rst}, 4'h1)
      `CHK(run_clk, 1'b0)
      $display("Test reset_state done");
   endtask : t_reset_state

   // Pin release: phase exit, pull-down release, strap sampling
   task automatic t_release(input logic [1:0] exp_st);
      int n;
      hold = 1'b0;
      for (n = 1; n <= 200; n++) begin
         @(negedge sys_clk_i);
         if (n == 2) `CHK({in_rst, pad.rst_pd_en}, 2'h3)
         if (n == 4) begin
            `CHK({in_rst, pad.host_hiz, pad.host_pu_en}, 3'h1)
            `CHK({rf.oe, rf.pu_en, rf.pd_en}, 12'hf00)
            `CHK(rf.out, rf_val)
            `CHK({pad.strap_sampling, valid}, 2'h2)
         end
         if (n == PD - 1) `CHK(pad.rst_pd_en, 1'b1)
         if (n == PD) `CHK(pad.rst_pd_en, 1'b0)
         if (valid === 1'b1) break;
      end
      if (n > 200) begin
         err_count++;
         close_out();
      end
      `CHK(n, SD + 3)
      `CHK(st, exp_st)
      `CHK(pad.strap_sampling, 1'b0)
      $display("Test release done");
   endtask : t_release

   // Software pull controls and synchronised request pins
   task automatic t_sw_ctl;
      `CHK({pad.req_pd_en, pad.host_pu_en}, 2'h3)
      sw = 3'h7;
      reg_req = 1'b1;
      pwm_req = 1'b1;
      repeat (3) @(negedge sys_clk_i);
      `CHK({pad.rst_pd_en, pad.req_pd_en, pad.host_pu_en}, 3'h4)
      `CHK({reg_o, pwm_o}, 2'h3)
      sw = 3'h0;
      reg_req = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      `CHK({pad.rst_pd_en, pad.req_pd_en, pad.host_pu_en}, 3'h3)
      `CHK({reg_o, pwm_o}, 2'h1)
      $display("Test sw_ctl done");
   endtask : t_sw_ctl

   // Clock request in either mode, with and without sleep
   task automatic t_clkreq(input logic pp);
      logic [2:0] cases;
      for (int i = 0; i < 3; i++) begin
         cases = (i == 0) ? 3'h2 : (i == 1) ? 3'h0 : 3'h3;  // {want, sleep}
         want = cases[1];
         sleep = cases[0];
         repeat (2) @(negedge sys_clk_i);
         if (pp) `CHK({ck.out, ck.oe, ck.pd_en}, {i == 0, 2'h2})
         else `CHK({ck.out, ck.oe, ck.pd_en}, (i == 0) ? 3'h6 : 3'h5)
         `CHK(run_clk, i == 0)
      end
      want = 1'b0;
      sleep = 1'b0;
      $display("Test clkreq done");
   endtask : t_clkreq

   // Clock enable low freezes the clock request, high lets it follow again
   task automatic t_freeze;
      clk_en = 1'b0;
      want = 1'b1;
      repeat (3) @(negedge sys_clk_i);
      `CHK({ck.out, ck.oe, ck.pd_en}, 3'h5)
      clk_en = 1'b1;
      @(negedge sys_clk_i);
      `CHK({ck.out, ck.oe, ck.pd_en}, 3'h6)
      want = 1'b0;
      $display("Test freeze done");
   endtask : t_freeze

   // Pin reset, override straps, later strap changes are ignored
   task automatic t_reenter;
      hold = 1'b1;
      ovr_en = 2'h3;
      ovr_val = 2'h3;
      repeat (4) @(negedge sys_clk_i);
      t_reset_state();
      t_release(2'h3);
      t_clkreq(1'b1);
      ovr_val = 2'h0;
      repeat (4) @(negedge sys_clk_i);
      `CHK({st, valid}, 3'h7)
      $display("Test reenter done");
   endtask : t_reenter

   // Main sequence
   initial begin
      reg_req = 1'b0;
      pwm_req = 1'b0;
      want = 1'b0;
      sleep = 1'b0;
      repeat (6) @(negedge sys_clk_i);
      srst_i = 1'b0;
      @(negedge sys_clk_i);
      t_reset_state();
      t_release(2'h0);
      t_sw_ctl();
      t_clkreq(1'b0);
      t_freeze();
      t_reenter();
      close_out();
   end
endmodule : testbench
